// ---- core/sscc_core.sv ----
// speed sensor calibration core: edges, offset, modes, pulse trigger
// What this block does
// R1: first pulse on first recognised rising edge
// R2: second pulse on next rising edge
// R3: uncalibrated pulses use noise-detection threshold
// R4: threshold starts 2x limit, adapts, floors there
// R5: peak detection yields offset from extrema
// R6: offset update needs two extrema, matching slope
// R7: positive correction rising only, negative falling
// R8: offset update independent of output switching
// R9: offset drives the correction converter
// R10: successful correction enters calibrated mode
// R11: calibrated switching at adaptive hysteresis
// R12: calibrated threshold keeps adapting to amplitude
// R13: small amplitude: first two pulses, third suppressible
// R14: small amplitude: fourth pulse calibrated with direction
// R15: direction encoded into output pulse kind
// R16: first pulse is plain speed pulse
// R17: hysteresis quarter amplitude, floored at limit
// R18: sampled detection, mode cleared on reset
`timescale 1ns/100ps
`include "sscc_map.svh"
module sscc_core #(
  parameter int          W       = `SSCC_SMP_W,
  parameter int          OW      = `SSCC_OFS_W,
  parameter logic [11:0] LIMIT   = `SSCC_LIMIT_DEF,
  parameter int          PULSE_NS = `SSCC_PULSE_NS
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // digitized speed and direction samples
  input  wire logic                smp_valid,
  input  wire logic signed [W-1:0] speed_smp,
  input  wire logic                dir_bit,
  // offset correction converter
  output logic signed [OW-1:0]     ofs_dac,
  output logic                     ofs_load,
  // pulse trigger toward output protocol
  output logic                     pulse_req,
  output sscc_pkg::sscc_pulse_e    pulse_kind,
  // status
  output logic                     calibrated,
  output logic [W-1:0]             noise_detection_threshold,
  output logic [W-1:0]             hyst_level
);
  import sscc_pkg::*;
  localparam int PULSE_CYC = (PULSE_NS + `SSCC_CLK_NS - 1) / `SSCC_CLK_NS;
  localparam logic [W-1:0] LIM = LIMIT[W-1:0];
  localparam logic [W-1:0] LIM2 = LIM << `SSCC_DNC_SHIFT;

  sscc_slope_if sl ();
  logic [W-1:0] th_r, th_nxt, hy_r, hy_nxt;

  // edge and extremum tracker on sample stream
  sscc_tracker #(.W(W)) u_trk (
    .clk       (clk),
    .nrst      (nrst),
    .smp_valid (smp_valid),
    .smp       (speed_smp),
    .noise_th  (calibrated ? hy_r : th_r), // R3 R11
    .so        (sl)
  );

  // extrema bookkeeping and amplitude estimate
  logic signed [W-1:0] max_r, max_nxt, min_r, min_nxt;
  logic [1:0]          next_r, next_nxt;
  logic [W:0]          amp;
  logic [W-1:0]        amp_w;
  always_comb begin
    max_nxt  = max_r;
    min_nxt  = min_r;
    next_nxt = next_r;
    if (sl.peak_max) begin
      max_nxt = sl.ext_value; // R5
      if (next_r != `SSCC_EXT_NEED) next_nxt = next_r + 2'h1;
    end
    if (sl.peak_min) begin
      min_nxt = sl.ext_value; // R5
      if (next_r != `SSCC_EXT_NEED) next_nxt = next_r + 2'h1;
    end
  end
  assign amp   = {max_r[W-1], max_r} - {min_r[W-1], min_r};
  assign amp_w = amp[W] ? '0 : amp[W-1:0];

  // thresholds: noise detection and adaptive hysteresis
  always_comb begin
    th_nxt = th_r;
    hy_nxt = hy_r;
    if (next_r == `SSCC_EXT_NEED && (sl.peak_max || sl.peak_min)) begin
      th_nxt = (amp_w >> `SSCC_AMP_SHIFT) < LIM2 ?
               LIM2 : (amp_w >> `SSCC_AMP_SHIFT); // R4 R12
      hy_nxt = (amp_w >> `SSCC_HYST_SHIFT) < LIM ?
               LIM : (amp_w >> `SSCC_HYST_SHIFT); // R17
    end
  end

  // offset computation: midpoint of extrema, applied on matching slope
  logic signed [OW-1:0] ofs_r, ofs_nxt;
  logic                 load_r, load_nxt, cal_r, cal_nxt;
  logic                 pend_r, pend_nxt;
  logic signed [W:0]    mid;
  logic signed [OW-1:0] tgt;
  always_comb begin
    mid      = $signed({max_r[W-1], max_r} + {min_r[W-1], min_r}) >>> 1;
    tgt      = ofs_r - mid[OW-1:0]; // R5
    ofs_nxt  = ofs_r;
    load_nxt = 1'b0;
    cal_nxt  = cal_r;
    pend_nxt = pend_r;
    // one update per fresh extremum, else the offset runs away
    if ((sl.peak_max || sl.peak_min) && next_nxt == `SSCC_EXT_NEED)
      pend_nxt = 1'b1; // R6
    // runs every sample, regardless of pulse state
    else if (pend_r && smp_valid && next_r == `SSCC_EXT_NEED) begin // R6 R8
      if (tgt > ofs_r && sl.slope == SSCC_SLOPE_RISE) begin // R7
        ofs_nxt  = tgt;
        load_nxt = 1'b1; // R9
        cal_nxt  = 1'b1; // R10
        pend_nxt = 1'b0;
      end else if (tgt < ofs_r && sl.slope == SSCC_SLOPE_FALL) begin // R7
        ofs_nxt  = tgt;
        load_nxt = 1'b1; // R9
        cal_nxt  = 1'b1; // R10
        pend_nxt = 1'b0;
      end else if (tgt == ofs_r) begin
        cal_nxt  = 1'b1; // R10
        pend_nxt = 1'b0;
      end
    end
  end

  // pulse sequencing
  logic [2:0]  cnt_r, cnt_nxt;
  logic        small_r, small_nxt;
  logic        preq_nxt;
  sscc_pulse_e kind_r, kind_nxt;
  logic [$clog2(PULSE_CYC+1)-1:0] gap_r, gap_nxt;
  always_comb begin
    cnt_nxt   = cnt_r;
    preq_nxt  = 1'b0;
    kind_nxt  = kind_r;
    gap_nxt   = gap_r == '0 ? gap_r : gap_r - 1'b1;
    small_nxt = small_r;
    if (sl.peak_max || sl.peak_min)
      small_nxt = amp_w < LIM2; // R13
    if (sl.rise_edge && gap_r == '0) begin // R1 R2 R3 R11
      preq_nxt = 1'b1;
      gap_nxt  = PULSE_CYC[$bits(gap_r)-1:0];
      if (cnt_r != `SSCC_CAL_IDX) cnt_nxt = cnt_r + 3'h1;
      if (cnt_r == '0 || !cal_r)
        kind_nxt = SSCC_PULSE_SPEED; // R16
      else
        kind_nxt = dir_bit ? SSCC_PULSE_REV : SSCC_PULSE_FWD; // R14 R15
      if (!cal_r && small_r && cnt_r == `SSCC_SUPP_IDX - 3'h1)
        preq_nxt = 1'b0; // R13
    end
  end

  // all state registers
  always_ff @(posedge clk) begin
    if (!nrst) begin // R18
      max_r   <= '0;
      min_r   <= '0;
      next_r  <= '0;
      th_r    <= LIM2; // R4
      hy_r    <= LIM;
      ofs_r   <= '0;
      load_r  <= 1'b0;
      pend_r  <= 1'b0;
      cal_r   <= 1'b0;
      cnt_r   <= '0;
      small_r <= 1'b0;
      kind_r  <= SSCC_PULSE_NONE;
      gap_r   <= '0;
      pulse_req <= 1'b0;
    end else begin
      max_r   <= max_nxt;
      min_r   <= min_nxt;
      next_r  <= next_nxt;
      th_r    <= th_nxt;
      hy_r    <= hy_nxt;
      ofs_r   <= ofs_nxt;
      load_r  <= load_nxt;
      pend_r  <= pend_nxt;
      cal_r   <= cal_nxt;
      cnt_r   <= cnt_nxt;
      small_r <= small_nxt;
      kind_r  <= kind_nxt;
      gap_r   <= gap_nxt;
      pulse_req <= preq_nxt;
    end
  end

  assign ofs_dac    = ofs_r;
  assign ofs_load   = load_r;
  assign pulse_kind = kind_r;
  assign calibrated = cal_r;
  assign noise_detection_threshold = th_r;
  assign hyst_level = hy_r;
endmodule

// ---- core/sscc_map.svh ----
// register-free constants for the speed sensor calibration core
`ifndef SSCC_MAP_SVH
`define SSCC_MAP_SVH
`define SSCC_SMP_W        12
`define SSCC_OFS_W        10
`define SSCC_LIMIT_DEF    12'h040
`define SSCC_DNC_SHIFT    1
`define SSCC_HYST_SHIFT   2
`define SSCC_AMP_SHIFT    1
`define SSCC_EXT_NEED     2'h2
`define SSCC_PULSE_NS     1000
`define SSCC_CLK_NS       10
`define SSCC_SUPP_IDX     3'h3
`define SSCC_CAL_IDX      3'h4
`endif

// ---- core/sscc_pkg.sv ----
// types for the speed sensor calibration core
package sscc_pkg;
  typedef enum logic [1:0] {
    SSCC_PULSE_NONE,
    SSCC_PULSE_SPEED,
    SSCC_PULSE_FWD,
    SSCC_PULSE_REV
  } sscc_pulse_e;
  typedef enum logic [1:0] {
    SSCC_SLOPE_UNKNOWN,
    SSCC_SLOPE_RISE,
    SSCC_SLOPE_FALL
  } sscc_slope_e;
endpackage

// ---- core/sscc_slope_if.sv ----
// slope tracking signals passed from the tracker to the core
`timescale 1ns/100ps
interface sscc_slope_if;
  import sscc_pkg::*;
  logic                         rise_edge;
  logic                         peak_max;
  logic                         peak_min;
  logic signed [11:0]           ext_value;
  sscc_slope_e                  slope;
  modport src (output rise_edge, peak_max, peak_min, ext_value, slope);
  modport dst (input rise_edge, peak_max, peak_min, ext_value, slope);
endinterface

// ---- core/sscc_tracker.sv ----
// sample-to-sample slope and extremum tracker
`timescale 1ns/100ps
`include "sscc_map.svh"
module sscc_tracker #(
  parameter int W = `SSCC_SMP_W
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // sample stream
  input  wire logic              smp_valid,
  input  wire logic signed [W-1:0] smp,
  input  wire logic [W-1:0]      noise_th,
  // results
  sscc_slope_if.src              so
);
  import sscc_pkg::*;
  logic signed [W-1:0] ext_r, ext_nxt;
  sscc_slope_e         slope_r, slope_nxt;
  logic                rise_r, rise_nxt, pmax_r, pmax_nxt, pmin_r, pmin_nxt;
  logic signed [W:0]   diff;

  // slope direction flips once sample leaves the held extremum by threshold
  always_comb begin
    ext_nxt   = ext_r;
    slope_nxt = slope_r;
    rise_nxt  = 1'b0;
    pmax_nxt  = 1'b0;
    pmin_nxt  = 1'b0;
    diff      = {smp[W-1], smp} - {ext_r[W-1], ext_r};
    if (smp_valid) begin // R18
      unique case (slope_r)
        SSCC_SLOPE_RISE: begin
          if (smp > ext_r) ext_nxt = smp;
          else if (-diff > $signed({2'b00, noise_th[W-2:0]})) begin
            pmax_nxt  = 1'b1; // R5
            slope_nxt = SSCC_SLOPE_FALL;
            ext_nxt   = smp;
          end
        end
        default: begin
          if (smp < ext_r || slope_r == SSCC_SLOPE_UNKNOWN && smp > ext_r &&
              diff <= $signed({2'b00, noise_th[W-2:0]})) begin
            if (smp < ext_r) ext_nxt = smp;
          end else if (diff > $signed({2'b00, noise_th[W-2:0]})) begin
            rise_nxt  = 1'b1; // R1
            pmin_nxt  = (slope_r == SSCC_SLOPE_FALL); // R5
            slope_nxt = SSCC_SLOPE_RISE;
            ext_nxt   = smp;
          end
        end
      endcase
    end
  end

  // tracker registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ext_r   <= '0;
      slope_r <= SSCC_SLOPE_UNKNOWN;
      rise_r  <= 1'b0;
      pmax_r  <= 1'b0;
      pmin_r  <= 1'b0;
    end else begin
      ext_r   <= ext_nxt;
      slope_r <= slope_nxt;
      rise_r  <= rise_nxt;
      pmax_r  <= pmax_nxt;
      pmin_r  <= pmin_nxt;
    end
  end

  assign so.rise_edge = rise_r;
  assign so.peak_max  = pmax_r;
  assign so.peak_min  = pmin_r;
  assign so.ext_value = ext_r;
  assign so.slope     = slope_r;
endmodule

// ---- test/sscc_core_monitor.sv ----
// assertion checker on the calibration core ports
`timescale 1ns/100ps
module sscc_core_monitor
  import sscc_pkg::*;
#(
  parameter logic [11:0] LIMIT = 12'h040
) (
  // clock and reset
  input wire logic               clk,
  input wire logic               nrst,
  // observed outputs
  input wire logic signed [9:0]  ofs_dac,
  input wire logic               ofs_load,
  input wire logic               pulse_req,
  input wire sscc_pulse_e        pulse_kind,
  input wire logic               calibrated,
  input wire logic [11:0]        noise_detection_threshold,
  input wire logic [11:0]        hyst_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // pulse timing and kind
  property p_gap;
    pulse_req |=> !pulse_req [*8];
  endproperty
  a_gap: assert property (p_gap)
    else $error("pulse requests too close");
  property p_kind;
    pulse_req |-> pulse_kind != SSCC_PULSE_NONE;
  endproperty
  a_kind: assert property (p_kind)
    else $error("pulse without kind");
  property p_unc;
    pulse_req && !calibrated |-> pulse_kind == SSCC_PULSE_SPEED;
  endproperty
  a_unc: assert property (p_unc)
    else $error("uncalibrated pulse carries direction");
  property p_cal;
    pulse_req && calibrated |->
      pulse_kind inside {SSCC_PULSE_FWD, SSCC_PULSE_REV};
  endproperty
  a_cal: assert property (p_cal)
    else $error("calibrated pulse lacks direction");
  // offset converter update
  property p_load;
    ofs_load |=> !ofs_load;
  endproperty
  a_load: assert property (p_load)
    else $error("offset load longer than one cycle");
  property p_ofs;
    $changed(ofs_dac) |-> ofs_load;
  endproperty
  a_ofs: assert property (p_ofs)
    else $error("offset changed without load");
  // mode and thresholds
  property p_sticky;
    calibrated |=> calibrated;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("calibrated mode dropped");
  property p_nfloor;
    noise_detection_threshold >= (LIMIT << 1);
  endproperty
  a_nfloor: assert property (p_nfloor)
    else $error("noise threshold below floor");
  property p_hfloor;
    hyst_level >= LIMIT;
  endproperty
  a_hfloor: assert property (p_hfloor)
    else $error("hysteresis below floor");
  property p_rst;
    $rose(nrst) |-> !calibrated && ofs_dac == 0 && !pulse_req &&
      noise_detection_threshold == (LIMIT << 1);
  endproperty
  a_rst: assert property (p_rst)
    else $error("state not cleared by reset");
endmodule

// ---- test/sscc_core_tb_top.sv ----
// testbench for the speed sensor calibration core
`timescale 1ns/100ps
module sscc_core_tb_top;
  import sscc_pkg::*;
  localparam logic [11:0] LIM = 12'h040;
  localparam int          DC  = 96;
  logic               clk, nrst, smp_valid, dir_bit, ofs_load;
  logic               pulse_req, calibrated;
  logic signed [11:0] speed_smp;
  logic signed [9:0]  ofs_dac;
  logic [11:0]        nthr, hyst;
  sscc_pulse_e        pulse_kind;
  int                 num_errors, checks, n_pulse, n_dir, ph;
  int                 nd0, n_load;
  logic [31:0]        lfsr;
  sscc_pulse_e        expq[$];
  sscc_core #(.LIMIT(LIM)) dut (.clk, .nrst, .smp_valid, .speed_smp,
    .dir_bit, .ofs_dac, .ofs_load, .pulse_req, .pulse_kind, .calibrated,
    .noise_detection_threshold(nthr), .hyst_level(hyst));
  sscc_tcu_model u_tcu (.clk, .pulse_req, .pulse_kind, .n_pulse, .n_dir);
  // clock
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr_next(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(logic [11:0] seen, logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // triangle wave with offset, noise and converter feedback
  task automatic run(int n);
    int v;
    repeat (n * 256) begin
      @(negedge clk);
      lfsr = lfsr_next(lfsr);
      smp_valid = |lfsr[3:2]; // random gaps in the sample stream
      v = (ph < 128) ? (ph - 64) * 8 : (192 - ph) * 8;
      v += DC + int'(ofs_dac) + int'(lfsr[1:0]) - 1;
      speed_smp = 12'(v);
      ph = (ph + 1) % 256;
    end
  endtask
  task automatic restart();
    nrst = 0;
    repeat (6) @(negedge clk);
    check(nthr, LIM << 1);
    check({11'h0, calibrated}, 12'h000);
    expq = {SSCC_PULSE_SPEED, SSCC_PULSE_SPEED};
    ph = 0;
    nrst = 1;
    run(12);
    check({11'h0, calibrated}, 12'h001);
    check(12'(expq.size()), 12'h000);
  endtask
  // compare each pulse with the oldest note, else a calibrated pulse with the direction
  always @(posedge clk) begin
    if (nrst && ofs_load === 1'b1)
      n_load++;
    if (nrst && pulse_req === 1'b1) begin
      if (expq.size() > 0)
        check(pulse_kind, expq.pop_front());
      else if (calibrated === 1'b1)
        check(pulse_kind, dir_bit ? SSCC_PULSE_REV : SSCC_PULSE_FWD);
    end
  end
  // main sequence
  initial begin
    {nrst, dir_bit, speed_smp, ph} = 0;
    smp_valid = 1;
    {num_errors, checks, n_load} = 0;
    lfsr = 32'hF04761CC;
    restart();
    check({11'h0, int'(ofs_dac) + DC inside {[-8:8]}}, 12'h001);
    check({11'h0, nthr > (LIM << 1)}, 12'h001);
    check({11'h0, hyst > LIM}, 12'h001);
    check({11'h0, n_load > 0}, 12'h001);
    dir_bit = 1;
    nd0 = n_dir;
    run(4);
    check({11'h0, n_dir - nd0 > 2}, 12'h001);
    restart();
    summarize();
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end
endmodule
bind sscc_core sscc_core_monitor #(.LIMIT(LIMIT)) u_mon (.clk, .nrst,
  .ofs_dac, .ofs_load, .pulse_req, .pulse_kind, .calibrated,
  .noise_detection_threshold, .hyst_level);

// ---- test/sscc_tcu_model.sv ----
// receiver model tallying trigger pulses and direction pulses
`timescale 1ns/100ps
module sscc_tcu_model
  import sscc_pkg::*;
(
  // clock and pulse input
  input wire logic         clk,
  input wire logic         pulse_req,
  input wire sscc_pulse_e  pulse_kind,
  // tallies
  output int               n_pulse,
  output int               n_dir
);
  // count every pulse, and those with direction content
  initial begin
    n_pulse = 0;
    n_dir = 0;
  end
  always @(posedge clk) begin
    if (pulse_req === 1'b1) begin
      n_pulse <= n_pulse + 1;
      if (pulse_kind inside {SSCC_PULSE_FWD, SSCC_PULSE_REV})
        n_dir <= n_dir + 1;
    end
  end
endmodule
